// ---- pic_pkg.sv ----
// Constants, bus carriers and state type of the cascaded interrupt block
package pic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MCMD = 8'h20;
	localparam logic [7:0] IDX_MDATA = 8'h21;
	localparam logic [7:0] IDX_SCMD = 8'ha0;
	localparam logic [7:0] IDX_SDATA = 8'ha1;
	localparam logic [7:0] IDX_GCTRL = 8'hd0;
	localparam logic [7:0] IDX_EDGELVL = 8'h10;
	localparam logic [7:0] IDX_PENDING = 8'h11;
	localparam logic [7:0] IDX_SERVICE = 8'h12;
	localparam logic [7:0] IDX_VEC = 8'h13;
	localparam logic [7:0] IDX_ISTAT = 8'h14;
	localparam logic [7:0] IDX_IMASK = 8'h15;
	// Field positions
	localparam int GC_KBD_LATCH = 11;
	localparam int GC_MOUSE_LATCH = 12;
	localparam logic [15:0] GC_WMASK = 16'h1800;
	localparam int INIT_BIT = 4;
	localparam int SVC_DONE_BIT = 5;
	localparam int AUTO_DONE_BIT = 1;
	localparam int EV_VECTOR = 0;
	localparam int EV_SPUR = 1;
	localparam logic [2:0] CASCADE_INPUT = 3'h2;
	localparam logic [2:0] CASCADE_CODE = 3'h2;
	localparam logic [2:0] SPURIOUS_IDX = 3'h7;
	localparam logic [15:0] FIXED_SENSE = 16'h2105;
	localparam logic [1:0] INIT_WORDS = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Reset values
	localparam logic [15:0] RST_MASK = 16'hffff;
	localparam logic [15:0] RST_ELCR = 16'h0000;

	typedef enum logic [1:0] {
		ACK_IDLE,
		ACK_FIRST,
		ACK_CASCADE,
		ACK_SECOND
	} ack_state_t;

	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;

	typedef struct packed {
		logic awHave;
		logic [11:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awReady;
		logic wReady;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [15:0] pending_request_bits;
		logic [15:0] in_service_bits;
		logic [15:0] mask;
		logic [15:0] elcr;
		logic [15:0] prevLine;
		logic [15:0] genCtrl;
		logic kbdPrev;
		logic mousePrev;
		logic kbdLatch;
		logic mouseLatch;
		logic [1:0][4:0] base;
		logic [2:0] slaveId;
		logic [1:0] automatic_end_of_interrupt;
		logic [1:0][1:0] initCnt;
		ack_state_t ackState;
		logic ackPulseN;
		logic [2:0] cascadeCode;
		logic [2:0] mIdx;
		logic [2:0] sIdx;
		logic spurious;
		logic slaveHit;
		logic slaveSel;
		logic [7:0] ackVector;
		logic vectorValid;
		logic intOut;
		logic [1:0] istat;
		logic [1:0] imask;
		logic irqOut;
	} pic_state_t;

	localparam pic_state_t RST_STATE = '{
		mask: RST_MASK,
		elcr: RST_ELCR,
		slaveId: CASCADE_CODE,
		ackPulseN: 1'b1,
		ackState: ACK_IDLE,
		default: '0
	};
endpackage : pic_pkg

// ---- cascaded_pic.sv ----
// Two cascaded eight-input interrupt cores with acknowledge sequencer
//
// What this block does
// - Two eight-input cores; slave output feeds master input 2, fifteen levels.
// - Master 0 timer, master 2 slave, slave 0 clock, slave 5 float error.
// - Each input edge or level selectable, except levels 0, 2, 8, 13.
// - Keyboard and mouse request latching enabled by control bits 11, 12.
// - Request set by rising edge in edge mode, high level in level mode.
// - Request sets regardless of mask; masked request never raises interrupt.
// - Interrupt output active while an unmasked request not blocked by in-service is pending.
// - Acknowledging a level sets its in-service bit, clears request.
// - Each acknowledge transaction becomes two internal pulses to both cores.
// - First pulse samples requests, sets winner in-service, clears its request.
// - First pulse trailing edge: master broadcasts 3-bit select code to slave.
// - Second pulse: vector is base bits 7..3 plus input number.
// - No request left at acknowledge: master returns its input 7 vector.
// - Automatic mode clears in-service after second pulse, else on command.
// - Slave supplies the vector when the master drives the slave id, 010 after reset.
// - Input 0 highest; in-service blocks equal and lower priority requests.
// - Base port write with bit 4 starts init; three data writes follow.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module cascaded_pic (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire pic_pkg::axi_req_t axiReq,
	output pic_pkg::axi_rsp_t axiRsp,
	input wire logic timerOut0,
	input wire logic rtcIrqN,
	input wire logic floatErrorIrq,
	input wire logic [15:0] serializedIrqLine,
	input wire logic kbdPortRead,
	input wire logic pciIntAck,
	output logic processorInterruptOutput,
	output logic internalAckPulseN,
	output logic [2:0] cascadeCode,
	output logic [7:0] ackVector,
	output logic ackVectorValid,
	output logic irq
);
	pic_pkg::pic_state_t s;
	pic_pkg::pic_state_t n;
	logic [15:0] raw;
	logic [15:0] levelSel;
	logic [15:0] reqNext;
	logic [3:0] mWin;
	logic [3:0] sWin;
	logic [31:0] laneBits;
	logic [31:0] wd;
	logic [7:0] wIdx;
	logic [7:0] rIdx;
	logic wCore;
	logic wCmd;
	logic wDat;
	logic doWrite;
	logic [3:0] coreBase;

	// Highest unmasked request not blocked by an equal or higher service
	function automatic logic [3:0] pickWinner(
		input logic [7:0] req,
		input logic [7:0] msk,
		input logic [7:0] svc
	);
		logic [3:0] r;
		logic stop;
		r = 4'h0;
		stop = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (svc[i])
				stop = 1'b1;
			if (!stop && req[i] && !msk[i]) begin
				r = {1'b1, 3'(i)};
				stop = 1'b1;
			end
		end
		return r;
	endfunction : pickWinner

	// Non-specific end of interrupt drops the top-priority service bit
	function automatic logic [7:0] dropTopService(input logic [7:0] svc);
		logic [7:0] r;
		logic done;
		r = svc;
		done = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (!done && svc[i]) begin
				r[i] = 1'b0;
				done = 1'b1;
			end
		end
		return r;
	endfunction : dropTopService

	// Address decode shared by both bus directions
	function automatic logic isMapped(input logic [11:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		if (a[11:10] != 2'h0 || a[1:0] != 2'h0)
			return 1'b0;
		case (idx)
			pic_pkg::IDX_MCMD, pic_pkg::IDX_MDATA,
			pic_pkg::IDX_SCMD, pic_pkg::IDX_SDATA,
			pic_pkg::IDX_GCTRL, pic_pkg::IDX_EDGELVL,
			pic_pkg::IDX_PENDING, pic_pkg::IDX_SERVICE,
			pic_pkg::IDX_VEC, pic_pkg::IDX_ISTAT,
			pic_pkg::IDX_IMASK:
				return 1'b1;
			default:
				return 1'b0;
		endcase
	endfunction : isMapped

	// Input wiring of both cores; IRQ8 pin is active low
	always_comb begin
		raw = serializedIrqLine;
		raw[0] = timerOut0;
		raw[2] = 1'b0;
		raw[8] = ~rtcIrqN;
		raw[13] = floatErrorIrq;
		if (s.genCtrl[pic_pkg::GC_KBD_LATCH])
			raw[1] = s.kbdLatch;
		if (s.genCtrl[pic_pkg::GC_MOUSE_LATCH])
			raw[12] = s.mouseLatch;
	end

	// Fixed-sense levels ignore the edge/level select
	assign levelSel = s.elcr & ~pic_pkg::FIXED_SENSE;

	// Per-input request capture, independent of the mask
	genvar g;
	for (g = 0; g < 16; g++) begin : gen_req
		assign reqNext[g] = levelSel[g] ? raw[g] :
			(s.pending_request_bits[g] | (raw[g] & ~s.prevLine[g]));
	end

	// Both cores resolve on the current state
	assign sWin = pickWinner(s.pending_request_bits[15:8], s.mask[15:8], s.in_service_bits[15:8]);
	assign mWin = pickWinner(s.pending_request_bits[7:0], s.mask[7:0], s.in_service_bits[7:0]);

	// Write strobes and decode
	always_comb begin
		for (int i = 0; i < 4; i++)
			laneBits[8*i +: 8] = {8{s.wStrb[i]}};
		wd = s.wData & laneBits;
		wIdx = s.awAddr[9:2];
		rIdx = axiReq.araddr[9:2];
		wCore = (wIdx == pic_pkg::IDX_SCMD) || (wIdx == pic_pkg::IDX_SDATA);
		wCmd = (wIdx == pic_pkg::IDX_MCMD) || (wIdx == pic_pkg::IDX_SCMD);
		wDat = (wIdx == pic_pkg::IDX_MDATA) || (wIdx == pic_pkg::IDX_SDATA);
		doWrite = s.awHave && s.wHave && !s.bValid && isMapped(s.awAddr);
		coreBase = {wCore, 3'h0};
	end

	// Next-state logic; later assignments win, so hardware sets come last
	always_comb begin
		n = s;
		// Request capture; cascade input follows slave output level
		n.prevLine = raw;
		n.pending_request_bits = reqNext;
		n.pending_request_bits[pic_pkg::CASCADE_INPUT] = sWin[3];
		n.intOut = mWin[3];

		// Keyboard and mouse latches, cleared by the data port read
		n.kbdPrev = serializedIrqLine[1];
		n.mousePrev = serializedIrqLine[12];
		if (kbdPortRead) begin
			n.kbdLatch = 1'b0;
			n.mouseLatch = 1'b0;
		end
		if (serializedIrqLine[1] && !s.kbdPrev)
			n.kbdLatch = 1'b1;
		if (serializedIrqLine[12] && !s.mousePrev)
			n.mouseLatch = 1'b1;

		// Write address and data taken in either order
		if (axiReq.awvalid && s.awReady) begin
			n.awHave = 1'b1;
			n.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && s.wReady) begin
			n.wHave = 1'b1;
			n.wData = axiReq.wdata;
			n.wStrb = axiReq.wstrb;
		end
		if (s.bValid && axiReq.bready)
			n.bValid = 1'b0;
		if (s.awHave && s.wHave && !s.bValid) begin
			n.awHave = 1'b0;
			n.wHave = 1'b0;
			n.bValid = 1'b1;
			n.bResp = isMapped(s.awAddr) ? pic_pkg::RESP_OKAY :
				pic_pkg::RESP_SLVERR;
		end

		// Command port: init start or non-specific end of interrupt
		if (doWrite && wCmd && s.wStrb[0]) begin
			if (wd[pic_pkg::INIT_BIT]) begin
				n.initCnt[wCore] = pic_pkg::INIT_WORDS;
				n.mask[coreBase +: 8] = 8'h00;
				n.in_service_bits[coreBase +: 8] = 8'h00;
			end else if (wd[pic_pkg::SVC_DONE_BIT]) begin
				n.in_service_bits[coreBase +: 8] =
					dropTopService(s.in_service_bits[coreBase +: 8]);
			end
		end

		// Data port: three init words, otherwise the mask
		if (doWrite && wDat && s.wStrb[0]) begin
			case (s.initCnt[wCore])
				2'h3: n.base[wCore] = wd[7:3];
				2'h2: begin
					if (wCore)
						n.slaveId = wd[2:0];
				end
				2'h1: n.automatic_end_of_interrupt[wCore] = wd[pic_pkg::AUTO_DONE_BIT];
				default: n.mask[coreBase +: 8] = wd[7:0];
			endcase
			if (s.initCnt[wCore] != 2'h0)
				n.initCnt[wCore] = s.initCnt[wCore] - 2'h1;
		end

		// Control, sense select and interrupt registers
		if (doWrite) begin
			case (wIdx)
				pic_pkg::IDX_GCTRL:
					n.genCtrl = (s.genCtrl & ~laneBits[15:0]) |
						(wd[15:0] & pic_pkg::GC_WMASK);
				pic_pkg::IDX_EDGELVL:
					n.elcr = (s.elcr & ~laneBits[15:0]) | wd[15:0];
				pic_pkg::IDX_ISTAT:
					n.istat = s.istat & ~wd[1:0];
				pic_pkg::IDX_IMASK:
					n.imask = (s.imask & ~laneBits[1:0]) | wd[1:0];
				default: ;
			endcase
		end

		// Acknowledge sequencer: one transaction, two internal pulses
		case (s.ackState)
			pic_pkg::ACK_IDLE: begin
				if (pciIntAck) begin
					n.ackState = pic_pkg::ACK_FIRST;
					n.ackPulseN = 1'b0;
				end
			end
			pic_pkg::ACK_FIRST: begin
				// Winners taken from this frozen snapshot
				n.ackPulseN = 1'b1;
				n.ackState = pic_pkg::ACK_CASCADE;
				n.spurious = !mWin[3];
				n.mIdx = mWin[3] ? mWin[2:0] : pic_pkg::SPURIOUS_IDX;
				n.cascadeCode = mWin[3] ? mWin[2:0] :
					pic_pkg::SPURIOUS_IDX;
				n.sIdx = sWin[3] ? sWin[2:0] : pic_pkg::SPURIOUS_IDX;
				n.slaveHit = 1'b0;
				if (mWin[3]) begin
					n.in_service_bits[mWin[2:0]] = 1'b1;
					n.pending_request_bits[mWin[2:0]] = 1'b0;
				end
				if (mWin[3] && mWin[2:0] == pic_pkg::CASCADE_INPUT &&
					sWin[3]) begin
					n.slaveHit = 1'b1;
					n.in_service_bits[{1'b1, sWin[2:0]}] = 1'b1;
					n.pending_request_bits[{1'b1, sWin[2:0]}] = 1'b0;
				end
			end
			pic_pkg::ACK_CASCADE: begin
				// Slave compares the broadcast code with its id
				n.ackPulseN = 1'b0;
				n.ackState = pic_pkg::ACK_SECOND;
				n.slaveSel = !s.spurious &&
					(s.cascadeCode == s.slaveId);
				n.ackVector = n.slaveSel ? {s.base[1], s.sIdx} :
					{s.base[0], s.mIdx};
				n.vectorValid = 1'b1;
				n.istat[pic_pkg::EV_VECTOR] = 1'b1;
				if (s.spurious)
					n.istat[pic_pkg::EV_SPUR] = 1'b1;
			end
			pic_pkg::ACK_SECOND: begin
				// Automatic end of interrupt at the second pulse end
				n.ackPulseN = 1'b1;
				n.vectorValid = 1'b0;
				n.ackState = pic_pkg::ACK_IDLE;
				if (s.automatic_end_of_interrupt[0] && !s.spurious)
					n.in_service_bits[s.mIdx] = 1'b0;
				if (s.automatic_end_of_interrupt[1] && s.slaveSel && s.slaveHit)
					n.in_service_bits[{1'b1, s.sIdx}] = 1'b0;
			end
			default: n.ackState = pic_pkg::ACK_IDLE;
		endcase
		n.irqOut = |(n.istat & n.imask);

		// Read channel; one read outstanding
		if (s.rValid && axiReq.rready)
			n.rValid = 1'b0;
		if (axiReq.arvalid && s.arReady) begin
			n.rValid = 1'b1;
			n.rResp = isMapped(axiReq.araddr) ? pic_pkg::RESP_OKAY :
				pic_pkg::RESP_SLVERR;
			n.rData = 32'h0;
			if (isMapped(axiReq.araddr)) begin
				case (rIdx)
					pic_pkg::IDX_MCMD: n.rData = 32'(s.pending_request_bits[7:0]);
					pic_pkg::IDX_MDATA: n.rData = 32'(s.mask[7:0]);
					pic_pkg::IDX_SCMD: n.rData = 32'(s.pending_request_bits[15:8]);
					pic_pkg::IDX_SDATA: n.rData = 32'(s.mask[15:8]);
					pic_pkg::IDX_GCTRL: n.rData = 32'(s.genCtrl);
					pic_pkg::IDX_EDGELVL: n.rData = 32'(s.elcr);
					pic_pkg::IDX_PENDING: n.rData = 32'(s.pending_request_bits);
					pic_pkg::IDX_SERVICE: n.rData = 32'(s.in_service_bits);
					pic_pkg::IDX_VEC: n.rData = 32'(s.ackVector);
					pic_pkg::IDX_ISTAT: n.rData = 32'(s.istat);
					pic_pkg::IDX_IMASK: n.rData = 32'(s.imask);
					default: n.rData = 32'h0;
				endcase
			end
		end

		// Readies drop while a transfer is held, so nothing is lost
		n.awReady = !n.awHave && !n.bValid;
		n.wReady = !n.wHave && !n.bValid;
		n.arReady = !n.rValid;
	end

	// Single state register
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			s <= pic_pkg::RST_STATE;
		else
			s <= n;
	end

	// All outputs taken straight from the state register
	assign axiRsp.awready = s.awReady;
	assign axiRsp.wready = s.wReady;
	assign axiRsp.bvalid = s.bValid;
	assign axiRsp.bresp = s.bResp;
	assign axiRsp.arready = s.arReady;
	assign axiRsp.rvalid = s.rValid;
	assign axiRsp.rdata = s.rData;
	assign axiRsp.rresp = s.rResp;
	assign processorInterruptOutput = s.intOut;
	assign internalAckPulseN = s.ackPulseN;
	assign cascadeCode = s.cascadeCode;
	assign ackVector = s.ackVector;
	assign ackVectorValid = s.vectorValid;
	assign irq = s.irqOut;
endmodule : cascaded_pic

// ---- pic_chk.sv ----
// Port-level checker for the cascaded interrupt block
`timescale 1ns/1ps
module pic_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire pic_pkg::axi_req_t axiReq,
	input wire pic_pkg::axi_rsp_t axiRsp,
	input wire logic pciIntAck,
	input wire logic internalAckPulseN,
	input wire logic [2:0] cascadeCode,
	input wire logic [7:0] ackVector,
	input wire logic ackVectorValid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [1:0] busy;
	// Sequencer busy window seen from the ports; requests inside are dropped
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 2'h0;
		end else if (pciIntAck && busy == 2'h0) begin
			busy <= 2'h3;
		end else if (busy != 2'h0) begin
			busy <= busy - 2'h1;
		end
	end
	chk_two_pulses: assert property (
		pciIntAck && busy == 2'h0 |=> !internalAckPulseN ##1 internalAckPulseN
		##1 (!internalAckPulseN && ackVectorValid) ##1 internalAckPulseN)
		else $error("acknowledge pulse pair malformed");
	chk_pulse_short: assert property (
		!internalAckPulseN |=> internalAckPulseN)
		else $error("acknowledge pulse longer than one cycle");
	chk_valid_once: assert property (
		ackVectorValid |=> !ackVectorValid)
		else $error("vector valid longer than one cycle");
	chk_code_trailing: assert property (
		$changed(cascadeCode) |-> internalAckPulseN
		&& $past(internalAckPulseN) == 1'b0)
		else $error("select code moved outside first pulse end");
	chk_vector_time: assert property (
		$changed(ackVector) |-> ackVectorValid)
		else $error("vector moved outside second pulse");
	chk_master_vector: assert property (
		ackVectorValid && cascadeCode != 3'h2 |-> ackVector[2:0] == cascadeCode)
		else $error("master vector low bits wrong");
	chk_bresp_hold: assert property (
		axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
		else $error("write response dropped early");
	chk_rdata_hold: assert property (
		axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read data dropped early");
endmodule : pic_chk

// ---- pic_host_model.sv ----
// Processor and bridge side: answers the interrupt line with acknowledges
`timescale 1ns/1ps
module pic_host_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic forceAck,
	input wire logic [3:0] delay,
	input wire logic interruptIn,
	input wire logic [7:0] vectorIn,
	input wire logic vectorValid,
	output logic pciIntAck,
	output logic [7:0] lastVector,
	output int ackCount
);
	logic busy;
	logic pending;
	logic [3:0] waited;
	// One transaction per request; a slow host waits delay cycles first
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pciIntAck <= 1'b0;
			busy <= 1'b0;
			pending <= 1'b0;
			waited <= 4'h0;
			lastVector <= 8'h00;
			ackCount <= 0;
		end else begin
			pciIntAck <= 1'b0;
			pending <= pending | forceAck;
			if (!busy && (enable && interruptIn || pending)) begin
				waited <= waited + 4'h1;
				if (waited >= delay) begin
					pciIntAck <= 1'b1;
					busy <= 1'b1;
					pending <= 1'b0;
					waited <= 4'h0;
				end
			end
			if (vectorValid) begin
				lastVector <= vectorIn;
				busy <= 1'b0;
				ackCount <= ackCount + 1;
			end
		end
	end
endmodule : pic_host_model

// ---- testbench.sv ----
// Self-checking bench for the cascaded interrupt block
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [18:0] ins;
		logic [7:0] vec;
		logic [15:0] in_service_bits;
	} row_t;
	logic clk_sys, sys_rst, timerOut0, rtcIrqN, floatErrorIrq, kbdPortRead;
	logic [15:0] serializedIrqLine;
	pic_pkg::axi_req_t axiReq;
	pic_pkg::axi_rsp_t axiRsp;
	logic pciIntAck, processorInterruptOutput, internalAckPulseN;
	logic [2:0] cascadeCode;
	logic [7:0] ackVector, lastVector;
	logic ackVectorValid, irq, enable, forceAck;
	logic [3:0] delay;
	logic [31:0] rdat;
	int ackCount, num_errors, comparisons;
	// Master base 08, slave base 70, slave id 2, normal end of interrupt
	logic [19:0] initSeq [8] = '{20'h08011, 20'h08408, 20'h08404, 20'h08401,
		20'h28011, 20'h28470, 20'h28402, 20'h28401};
	// Input pulses {float, clock, timer, lines}, vector and in-service
	row_t rows [10] = '{
		'{19'h00002, 8'h09, 16'h0002}, '{19'h10000, 8'h08, 16'h0001},
		'{19'h00050, 8'h0c, 16'h0010}, '{19'h00000, 8'h0e, 16'h0040},
		'{19'h20208, 8'h70, 16'h0104}, '{19'h00000, 8'h71, 16'h0204},
		'{19'h00000, 8'h0b, 16'h0008}, '{19'h40000, 8'h75, 16'h2004},
		'{19'h08000, 8'h77, 16'h8004}, '{19'h00080, 8'h0f, 16'h0080}};

	cascaded_pic u_dut (.clk_sys, .sys_rst, .axiReq, .axiRsp, .timerOut0,
		.rtcIrqN, .floatErrorIrq, .serializedIrqLine, .kbdPortRead, .pciIntAck,
		.processorInterruptOutput, .internalAckPulseN, .cascadeCode,
		.ackVector, .ackVectorValid, .irq);
	pic_host_model u_host (.clk_sys, .sys_rst, .enable, .forceAck, .delay,
		.interruptIn(processorInterruptOutput), .vectorIn(ackVector),
		.vectorValid(ackVectorValid), .pciIntAck, .lastVector, .ackCount);

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Address and data offered together, each dropped once taken
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hf;
		axiReq.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiRsp.wready) axiReq.wvalid <= 1'b0;
			if (axiRsp.bvalid) axiReq.bready <= 1'b0;
		end while (!axiRsp.bvalid);
	endtask : wr
	task rd(input logic [11:0] a, output logic [1:0] resp);
		@(posedge clk_sys);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (axiRsp.arready) axiReq.arvalid <= 1'b0;
			if (axiRsp.rvalid) axiReq.rready <= 1'b0;
			rdat = axiRsp.rdata;
			resp = axiRsp.rresp;
		end while (!axiRsp.rvalid);
	endtask : rd
	// One-cycle pulse on the chosen sources
	task drive(input logic [18:0] ins);
		@(posedge clk_sys);
		{floatErrorIrq, timerOut0, serializedIrqLine} <= {ins[18], ins[16:0]};
		rtcIrqN <= !ins[17];
		@(posedge clk_sys);
		{floatErrorIrq, timerOut0, serializedIrqLine} <= 18'h00000;
		rtcIrqN <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : drive
	task ack_wait;
		int n;
		n = ackCount;
		enable <= 1'b1;
		for (int k = 0; k < 60 && ackCount == n; k++) @(posedge clk_sys);
		enable <= 1'b0;
	endtask : ack_wait
	task end_of_interrupt_command;
		wr(12'h080, 32'h00000020);
		wr(12'h280, 32'h00000020);
	endtask : end_of_interrupt_command
	task stop_test;
		$display("errors %0d in %0d checks", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Watchdog sized well above the whole sequence
	initial begin
		repeat (30000) @(posedge clk_sys);
		num_errors++;
		stop_test;
	end
	initial begin
		logic [1:0] rr;
		{axiReq, timerOut0, floatErrorIrq, kbdPortRead} = '0;
		{serializedIrqLine, enable, forceAck, delay} = '0;
		rtcIrqN = 1'b1;
		sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rd(12'h084, rr);
		chk("mask reset", 32'h000000ff, rdat);
		rd(12'h3fc, rr);
		chk("unmapped resp", 32'h00000002, {30'h0, rr});
		foreach (initSeq[i]) wr(initSeq[i][19:8], {24'h0, initSeq[i][7:0]});
		// Table of single and competing requests
		foreach (rows[i]) begin
			drive(rows[i].ins);
			delay <= 4'(i % 3);
			ack_wait;
			chk("vector", {24'h0, rows[i].vec}, {24'h0, lastVector});
			rd(12'h048, rr);
			chk("in service", {16'h0, rows[i].in_service_bits}, rdat);
			end_of_interrupt_command;
		end
		// Masked request is recorded but stays silent
		wr(12'h084, 32'h000000ff);
		drive(19'h00020);
		chk("masked out", 32'h0, {31'h0, processorInterruptOutput});
		rd(12'h044, rr);
		chk("request", 32'h00000020, rdat);
		wr(12'h084, 32'h00000000);
		ack_wait;
		chk("vector", 32'h0000000d, {24'h0, lastVector});
		end_of_interrupt_command;
		// Status bits, their mask and write-one clear
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(12'h054, 32'h00000003);
		repeat (2) @(posedge clk_sys);
		chk("irq", 32'h1, {31'h0, irq});
		wr(12'h050, 32'h00000003);
		repeat (2) @(posedge clk_sys);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// Fixed-sense timer stays edge; level 3 vanishes before acknowledge
		wr(12'h040, 32'h0000210d);
		drive(19'h10000);
		ack_wait;
		chk("vector", 32'h00000008, {24'h0, lastVector});
		end_of_interrupt_command;
		serializedIrqLine <= 16'h0008;
		repeat (4) @(posedge clk_sys);
		chk("level out", 32'h1, {31'h0, processorInterruptOutput});
		serializedIrqLine <= 16'h0000;
		repeat (3) @(posedge clk_sys);
		forceAck <= 1'b1;
		@(posedge clk_sys);
		forceAck <= 1'b0;
		ack_wait;
		chk("vector", 32'h0000000f, {24'h0, lastVector});
		// Keyboard latch holds a level-sensed request until the port read
		wr(12'h340, 32'h00001800);
		rd(12'h340, rr);
		chk("gen ctrl", 32'h00001800, rdat);
		wr(12'h040, 32'h0000210f);
		drive(19'h00002);
		rd(12'h044, rr);
		chk("latched request", 32'h00000002, rdat);
		kbdPortRead <= 1'b1;
		@(posedge clk_sys);
		kbdPortRead <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(12'h044, rr);
		chk("latch cleared", 32'h0, rdat);
		wr(12'h040, 32'h0000210d);
		// Automatic end of interrupt on the master
		foreach (initSeq[i]) if (i < 4) wr(initSeq[i][19:8], i == 3 ?
			32'h00000003 : {24'h0, initSeq[i][7:0]});
		drive(19'h00002);
		ack_wait;
		rd(12'h048, rr);
		chk("auto in service", 32'h0, rdat);
		stop_test;
	end
endmodule : testbench
bind cascaded_pic pic_chk u_chk (.clk_sys, .sys_rst, .axiReq, .axiRsp,
	.pciIntAck, .internalAckPulseN, .cascadeCode, .ackVector, .ackVectorValid);
